/* File: pkg/rta_pkg.sv */
package rta_pkg;
  localparam int OSC_HZ = 32768;
  localparam int CLK_HZ = 10_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  // tamper filter times, ns
  localparam longint FILT1_NS = 3_900_000;
  localparam longint FILT2_NS = 15_625_000;
  localparam longint FILT3_NS = 31_250_000;
  localparam int FILT1_CYC = int'((FILT1_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int FILT2_CYC = int'((FILT2_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int FILT3_CYC = int'((FILT3_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int FILT_W = 11;
  // repeating alarm pulse
  localparam longint PULSE_MS = 250;
  localparam int PULSE_CYC = int'(PULSE_MS * CLK_HZ / 1000);
  localparam int PULSE_W = 22;
  // prescaler sample masks (osc cycles)
  localparam int PRE_W = 17;
  localparam logic [16:0] SMP_MASK_2HZ = 17'h03FFF;
  localparam logic [16:0] SMP_MASK_1HZ = 17'h07FFF;
  localparam logic [16:0] SMP_MASK_QHZ = 17'h1FFFF;
  // digital trim
  localparam int SEC_W = 16;
  localparam logic [15:0] SEC_LAST = 16'h7FFF;
  localparam int ACC_W = 22;
  localparam logic [21:0] PPM_STEP = 22'(20 * OSC_HZ);
  localparam logic [21:0] PPM_ONE = 22'(1_000_000);
  // register offsets
  localparam logic [4:0] A_STATUS = 5'h07;
  localparam logic [4:0] A_INTCTL = 5'h08;
  localparam logic [4:0] A_TAMPER = 5'h09;
  localparam logic [4:0] A_ATRIM = 5'h0A;
  localparam logic [4:0] A_DTRIM = 5'h0B;
  localparam logic [4:0] A_ALM0 = 5'h0C;
  localparam logic [4:0] A_ALM5 = 5'h11;
  // status bits, alarm enable bit and field codes
  localparam int ST_AUTO_CLEAR_ON_READ = 7;
  localparam int ST_ALM = 1;
  localparam int ST_EVT = 0;
  localparam int ALM_EN_BIT = 7;
  localparam logic [3:0] FSEL_OFF = 4'h0;
  localparam logic [3:0] FSEL_32K = 4'h1;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] RATE_ON = 2'h0;
  localparam logic [1:0] RATE_2HZ = 2'h1;
  localparam logic [1:0] RATE_1HZ = 2'h2;
  localparam logic [1:0] DELTA_M05 = 2'h1;
  localparam logic [1:0] DELTA_P05 = 2'h2;
  localparam logic [1:0] DELTA_P1 = 2'h3;
  localparam logic [5:0] CAP_MAX = 6'h3F;

  typedef struct packed {
    logic       enable;
    logic       halt_clock_on_tamper;
    logic       tamper_out_battery_disable;
    logic       tamper_pullup_disable;
    logic [1:0] tamper_sample_rate;
    logic [1:0] tamper_filter_time;
  } rta_tcfg_s;

  typedef struct packed {
    logic       alarm_repeat_select;
    logic       alarm_enable;
    logic       low_power;
    logic       out_battery_disable;
    logic [3:0] freq_output;
  } rta_intc_s;

  typedef struct packed {
    logic [1:0] battery_cap_delta;
    logic [5:0] analog_trim_code;
  } rta_atrim_s;

  // index 0 seconds .. 5 weekday
  typedef logic [5:0][7:0] rta_time_t;
endpackage

/* File: design/rta_tamper_alarm_trim.sv */
// Function
// - filter codes none, 3.9, 15.625, 31.25 ms
// - detect and stamp only while enabled
// - stamp only first event after flag clear
// - halt counting on tamper when halt set
// - time write resumes counting, clears halt bit
// - halt works only with detection enabled
// - battery disable bit silences tamper output
// - pull-up disable bit turns source off
// - six-bit cap code, bit5 inverted sense
// - battery cap delta 0, -0.5, +0.5, +1 pF
// - trim averages oscillator counts per second
// - trim sign bit2, 40 and 20 ppm
// - trim reaches all outputs except 32.768kHz
// - alarm bytes bit7 is compare enable
// - compare sec to weekday, no year
// - trigger when all enabled fields match
// - single mode sets flag, holds output low
// - repeat mode pulses output each match
// - repeat mode flags each trigger regardless
// - flag cleared by zero write or auto-read
// - repeat pulse active low, 250 ms
// - frequency selection overrides alarm on pin
// - high tamper sets flag, output, stamp
// - sample rate always, 2, 1, 1/4 Hz
module rta_tamper_alarm_trim #(
  parameter int PULSE_CYCLES = rta_pkg::PULSE_CYC
) (
  // clocks and reset
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                osc_clk,
  // register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [4:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  // time keeping
  input  wire rta_pkg::rta_time_t  time_now,
  input  wire logic                time_set_done,
  output logic                     sec_tick,
  output logic                     count_halt,
  output logic                     ts_capture,
  // power and tamper pins
  input  wire logic                on_battery,
  input  wire logic                tamper_input,
  output logic                     tamper_detect_out,
  output logic                     tamper_detect_oe,
  output logic                     tamper_pullup_en,
  // oscillator and shared output pin
  output logic      [5:0]          cap_trim_code,
  output logic                     freq_trim_en,
  input  wire logic                freq_output_wave,
  output logic                     irq_freq_output_out,
  output logic                     irq_freq_output_oe
);
  import rta_pkg::*;

  typedef struct packed {
    logic                bat_s1;
    logic                bat_s2;
    logic                ev_s1;
    logic                ev_s2;
    logic                ev_s3;
    logic                sc_s1;
    logic                sc_s2;
    logic                sc_s3;
    rta_tcfg_s           tcfg;
    rta_intc_s           intc;
    rta_atrim_s          atrim;
    logic [2:0]          dtrim;
    logic                auto_clear_on_read;
    logic                alarm_flag;
    logic                tamper_flag;
    logic                halt;
    rta_time_t           alarm;
    logic                match;
    logic [PULSE_W-1:0]  pulse;
    logic [7:0]          rdata;
    logic                ts_cap;
    logic                tick;
    logic                tdet_oe;
    logic                irq_oe;
    logic [5:0]          cap;
  } rta_clk_s;

  typedef struct packed {
    logic                rst_s1;
    logic                rst_s2;
    logic [10:0]         cfg_s1;
    logic [10:0]         cfg_s2;
    logic                in_s1;
    logic                in_s2;
    logic                lvl;
    logic                smp_lvl;
    logic [FILT_W-1:0]   fcnt;
    logic [PRE_W-1:0]    pre;
    logic                ev_tog;
    logic [SEC_W-1:0]    scnt;
    logic [SEC_W-1:0]    send;
    logic [ACC_W-1:0]    acc;
    logic                sec_tog;
  } rta_osc_s;

  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);

  rta_clk_s c_q, c_d;
  rta_osc_s o_q, o_d;

  function automatic logic [FILT_W-1:0] filt_len(input logic [1:0] code);
    case (code)
      2'h1:    filt_len = FILT_W'(FILT1_CYC);
      2'h2:    filt_len = FILT_W'(FILT2_CYC);
      default: filt_len = FILT_W'(FILT3_CYC);
    endcase
  endfunction

  function automatic logic samp_hit(input logic [1:0] rate, input logic [PRE_W-1:0] pre);
    case (rate)
      RATE_ON:  samp_hit = 1'b1;
      RATE_2HZ: samp_hit = (pre & SMP_MASK_2HZ) == '0;
      RATE_1HZ: samp_hit = (pre & SMP_MASK_1HZ) == '0;
      default:  samp_hit = (pre & SMP_MASK_QHZ) == '0;
    endcase
  endfunction

  // cap array in 0.5 pF units above the fixed part, bit5 flipped to linear
  function automatic logic [5:0] cap_units(input rta_atrim_s a, input logic bat);
    logic [6:0] u;
    u = {1'b0, ~a.analog_trim_code[5], a.analog_trim_code[4:0]};
    if (bat) begin
      case (a.battery_cap_delta)
        DELTA_M05: u = (u == '0) ? u : u - 7'd1;
        DELTA_P05: u = u + 7'd1;
        DELTA_P1:  u = u + 7'd2;
        default:   u = u;
      endcase
    end
    if (u > {1'b0, CAP_MAX}) begin
      u = {1'b0, CAP_MAX};
    end
    cap_units = {~u[5], u[4:0]};
  endfunction

  // ---------------- oscillator domain ----------------
  always_comb begin
    rta_tcfg_s  ocfg;
    logic [2:0] odtr;
    logic [ACC_W-1:0] nacc;
    logic       smp;
    ocfg = rta_tcfg_s'(o_q.cfg_s2[10:3]);
    odtr = o_q.cfg_s2[2:0];
    nacc = '0;
    smp = 1'b0;
    o_d = o_q;
    o_d.rst_s1 = reset;
    o_d.rst_s2 = o_q.rst_s1;
    o_d.cfg_s1 = {c_q.tcfg, c_q.dtrim};
    o_d.cfg_s2 = o_q.cfg_s1;
    o_d.in_s1 = tamper_input;
    o_d.in_s2 = o_q.in_s1;
    o_d.pre = o_q.pre + 1'b1;
    // level filter: excursions shorter than the window are dropped
    if (o_q.in_s2 == o_q.lvl || ocfg.tamper_filter_time == FILT_NONE) begin
      o_d.lvl = o_q.in_s2;
      o_d.fcnt = '0;
    end else if (o_q.fcnt + 1'b1 >= filt_len(ocfg.tamper_filter_time)) begin
      o_d.lvl = o_q.in_s2;
      o_d.fcnt = '0;
    end else begin
      o_d.fcnt = o_q.fcnt + 1'b1;
    end
    smp = samp_hit(ocfg.tamper_sample_rate, o_q.pre);
    // only a fresh high at a sample point toggles, so the toggle moves
    // slowly enough for the register clock to see each change
    // limitation: a level still high after a flag clear is not re-reported
    if (smp && ocfg.enable) begin
      if (o_q.lvl && !o_q.smp_lvl) begin
        o_d.ev_tog = ~o_q.ev_tog;
      end
      o_d.smp_lvl = o_q.lvl;
    end else if (!ocfg.enable) begin
      // re-enabling with the pin already high counts as an event
      o_d.smp_lvl = 1'b0;
    end
    // second length set by fractional ppm accumulator
    if (o_q.scnt == o_q.send) begin
      o_d.scnt = '0;
      o_d.sec_tog = ~o_q.sec_tog;
      nacc = o_q.acc + PPM_STEP * ACC_W'({odtr[1], odtr[0]} == 2'h0 ? 2'h0 : odtr[1:0]);
      if (nacc >= PPM_ONE) begin
        o_d.acc = nacc - PPM_ONE;
        o_d.send = odtr[2] ? SEC_LAST + 1'b1 : SEC_LAST - 1'b1;
      end else begin
        o_d.acc = nacc;
        o_d.send = SEC_LAST;
      end
    end else begin
      o_d.scnt = o_q.scnt + 1'b1;
    end
    if (o_q.rst_s2) begin
      o_d.lvl = 1'b0;
      o_d.smp_lvl = 1'b0;
      o_d.fcnt = '0;
      o_d.pre = '0;
      o_d.ev_tog = 1'b0;
      o_d.scnt = '0;
      o_d.send = SEC_LAST;
      o_d.acc = '0;
      o_d.sec_tog = 1'b0;
    end
  end

  always_ff @(posedge osc_clk) begin
    o_q <= o_d;
  end

  // ---------------- register clock domain ----------------
  always_comb begin
    logic ev_hit;
    logic sc_hit;
    logic det_en;
    logic bat;
    logic wr_sts;
    logic rd_clr;
    logic any_en;
    logic all_eq;
    logic act;
    logic trig;
    logic fo_on;
    logic drive;
    ev_hit = 1'b0;
    sc_hit = 1'b0;
    det_en = 1'b0;
    bat = 1'b0;
    wr_sts = 1'b0;
    rd_clr = 1'b0;
    any_en = 1'b0;
    all_eq = 1'b1;
    act = 1'b0;
    trig = 1'b0;
    fo_on = 1'b0;
    drive = 1'b0;
    c_d = c_q;
    c_d.bat_s1 = on_battery;
    c_d.bat_s2 = c_q.bat_s1;
    c_d.ev_s1 = o_q.ev_tog;
    c_d.ev_s2 = c_q.ev_s1;
    c_d.ev_s3 = c_q.ev_s2;
    c_d.sc_s1 = o_q.sec_tog;
    c_d.sc_s2 = c_q.sc_s1;
    c_d.sc_s3 = c_q.sc_s2;
    bat = c_q.bat_s2;
    det_en = c_q.tcfg.enable;
    ev_hit = (c_q.ev_s3 != c_q.ev_s2) && det_en;
    sc_hit = c_q.sc_s3 != c_q.sc_s2;
    wr_sts = reg_wr && reg_addr == A_STATUS;
    rd_clr = reg_rd && reg_addr == A_STATUS && c_q.auto_clear_on_read;
    fo_on = c_q.intc.freq_output != FSEL_OFF;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        A_STATUS: c_d.auto_clear_on_read = reg_wdata[ST_AUTO_CLEAR_ON_READ];
        A_INTCTL: c_d.intc = rta_intc_s'(reg_wdata);
        A_TAMPER: c_d.tcfg = rta_tcfg_s'(reg_wdata);
        A_ATRIM:  c_d.atrim = rta_atrim_s'(reg_wdata);
        A_DTRIM:  c_d.dtrim = reg_wdata[2:0];
        default: begin
          if (reg_addr >= A_ALM0 && reg_addr <= A_ALM5) begin
            c_d.alarm[3'(reg_addr - A_ALM0)] = reg_wdata;
          end
        end
      endcase
    end
    // tamper flag: write of zero or auto-clear read, a new event wins
    if ((wr_sts && !reg_wdata[ST_EVT]) || rd_clr) begin
      c_d.tamper_flag = 1'b0;
    end
    if (ev_hit) begin
      c_d.tamper_flag = 1'b1;
    end
    c_d.ts_cap = ev_hit && !c_q.tamper_flag;
    // halt on tamper, released by a completed time write
    if (time_set_done) begin
      c_d.halt = 1'b0;
      c_d.tcfg.halt_clock_on_tamper = 1'b0;
    end
    if (ev_hit && c_q.tcfg.halt_clock_on_tamper) begin
      c_d.halt = 1'b1;
    end
    // new enable value, so a disabling write drops the halt at once
    if (!c_d.tcfg.enable) begin
      c_d.halt = 1'b0;
    end
    c_d.tick = sc_hit && !c_q.halt;
    // alarm compare over six fields, bit7 enables each
    any_en = 1'b0;
    all_eq = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (c_q.alarm[i][ALM_EN_BIT]) begin
        any_en = 1'b1;
        if (c_q.alarm[i][6:0] != time_now[i][6:0]) begin
          all_eq = 1'b0;
        end
      end
    end
    c_d.match = any_en && all_eq;
    act = c_q.intc.alarm_enable && !fo_on;
    trig = act && c_d.match && !c_q.match;
    if ((wr_sts && !reg_wdata[ST_ALM]) || rd_clr) begin
      c_d.alarm_flag = 1'b0;
    end
    if (trig) begin
      c_d.alarm_flag = 1'b1;
    end
    if (trig && c_q.intc.alarm_repeat_select) begin
      c_d.pulse = PULSE_LOAD;
    end else if (c_q.pulse != '0) begin
      c_d.pulse = c_q.pulse - 1'b1;
    end
    // shared pin: frequency overrides alarm, battery gate silences both
    if (fo_on) begin
      drive = !freq_output_wave;
    end else if (!c_q.intc.alarm_enable) begin
      drive = 1'b0;
    end else if (c_q.intc.alarm_repeat_select) begin
      drive = c_q.pulse != '0;
    end else begin
      drive = c_q.alarm_flag;
    end
    c_d.irq_oe = drive && !(bat && c_q.intc.out_battery_disable);
    c_d.tdet_oe = c_q.tamper_flag && det_en && !(bat && c_q.tcfg.tamper_out_battery_disable);
    c_d.cap = cap_units(c_q.atrim, bat);
    // read data
    if (reg_rd) begin
      case (reg_addr)
        A_STATUS: c_d.rdata = {c_q.auto_clear_on_read, 5'h00, c_q.alarm_flag, c_q.tamper_flag};
        A_INTCTL: c_d.rdata = c_q.intc;
        A_TAMPER: c_d.rdata = c_q.tcfg;
        A_ATRIM:  c_d.rdata = c_q.atrim;
        A_DTRIM:  c_d.rdata = {5'h00, c_q.dtrim};
        default: begin
          if (reg_addr >= A_ALM0 && reg_addr <= A_ALM5) begin
            c_d.rdata = c_q.alarm[3'(reg_addr - A_ALM0)];
          end else begin
            c_d.rdata = 8'h00;
          end
        end
      endcase
    end
    if (reset) begin
      c_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    c_q <= c_d;
  end

  assign reg_rdata = c_q.rdata;
  assign sec_tick = c_q.tick;
  assign count_halt = c_q.halt;
  assign ts_capture = c_q.ts_cap;
  assign tamper_detect_out = 1'b0;
  assign tamper_detect_oe = c_q.tdet_oe;
  assign tamper_pullup_en = !c_q.tcfg.tamper_pullup_disable;
  assign cap_trim_code = c_q.cap;
  assign freq_trim_en = c_q.intc.freq_output != FSEL_32K;
  assign irq_freq_output_out = 1'b0;
  assign irq_freq_output_oe = c_q.irq_oe;
endmodule // rta_tamper_alarm_trim

/* File: dv/rta_host_model.sv */
module rta_host_model (
  // register port
  input  wire logic       clock,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;
  // strobe held to the taking edge, dropped just after it
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge clock);
    #1;
    {reg_wr, reg_rd} = 2'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask
endmodule // rta_host_model

/* File: dv/rta_checker.sv */
module rta_checker #(
  parameter int PULSE_CYCLES = 50
) (
  // clock, reset, writes
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // watched pins
  input wire logic       time_set_done,
  input wire logic       count_halt,
  input wire logic       sec_tick,
  input wire logic       ts_capture,
  input wire logic       on_battery,
  input wire logic       tamper_detect_out,
  input wire logic       tamper_detect_oe,
  input wire logic       tamper_pullup_en,
  input wire logic       freq_trim_en,
  input wire logic       irq_freq_output_out,
  input wire logic       irq_freq_output_oe
);
  import rta_pkg::*;
  logic        wr_tamp;
  logic [7:0]  ictl_q;
  logic [21:0] run_q;
  assign wr_tamp = reg_wr && reg_addr == A_TAMPER;
  // mode shadow so pulse length is judged in repeat mode only
  always_ff @(posedge clock) begin
    if (reset) ictl_q <= 8'h00;
    else if (reg_wr && reg_addr == A_INTCTL && !on_battery) ictl_q <= reg_wdata;
    if (reset || !irq_freq_output_oe) run_q <= 22'h000000;
    else run_q <= run_q + 22'h000001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  halt_no_tick_a: assert property (count_halt |-> !sec_tick)
    else $error("second tick while halted");
  halt_release_a: assert property (time_set_done |=> !count_halt)
    else $error("halt kept after time write");
  halt_gate_a: assert property (wr_tamp && !reg_wdata[7] |=> !count_halt)
    else $error("halt while detection off");
  pullup_bit_a: assert property (wr_tamp |=> tamper_pullup_en == !$past(reg_wdata[4]))
    else $error("pull-up source wrong");
  trim_reach_a: assert property (reg_wr && reg_addr == A_INTCTL && !on_battery
    |=> freq_trim_en == ($past(reg_wdata[3:0]) != FSEL_32K)) else $error("trim reach wrong");
  stamp_out_a: assert property (ts_capture && !on_battery |-> ##[1:2] tamper_detect_oe)
    else $error("stamp without output");
  stamp_once_a: assert property (tamper_detect_oe && $past(tamper_detect_oe) |-> !ts_capture)
    else $error("second stamp while flagged");
  open_drain_a: assert property (!tamper_detect_out && !irq_freq_output_out)
    else $error("open drain data high");
  pulse_len_a: assert property (ictl_q == 8'hC0 && run_q == 22'(PULSE_CYCLES) |-> !irq_freq_output_oe)
    else $error("alarm pulse too long");
  cover property (ts_capture);
  cover property (time_set_done && count_halt);
  cover property ($fell(irq_freq_output_oe) && ictl_q == 8'hC0);
endmodule // rta_checker

bind rta_tamper_alarm_trim rta_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
  .clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .time_set_done(time_set_done), .count_halt(count_halt), .sec_tick(sec_tick),
  .ts_capture(ts_capture), .on_battery(on_battery), .tamper_detect_out(tamper_detect_out),
  .tamper_detect_oe(tamper_detect_oe), .tamper_pullup_en(tamper_pullup_en),
  .freq_trim_en(freq_trim_en), .irq_freq_output_out(irq_freq_output_out), .irq_freq_output_oe(irq_freq_output_oe)
);

/* File: dv/rta_tamper_alarm_trim_tb_top.sv */
module rta_tamper_alarm_trim_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rta_pkg::*;
  localparam int PULSE = 50;
  localparam int GLITCH[4] = '{2, 9, 38, 76};
  localparam int WIN[4] = '{40, 40, 100, 180};
  logic       clock = 1'b0, reset = 1'b1, osc_clk = 1'b0;
  logic       reg_wr, reg_rd, time_set_done, on_battery, tamper_input, freq_output_wave;
  logic       sec_tick, count_halt, ts_capture, tamper_detect_out, tamper_detect_oe;
  logic       tamper_pullup_en, freq_trim_en, irq_freq_output_out, irq_freq_output_oe;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [5:0] cap_trim_code;
  rta_time_t  time_now;
  int         miscompares = 0;
  int         num_checks = 0;

  rta_tamper_alarm_trim #(.PULSE_CYCLES(PULSE)) dut_u (
    .clock(clock), .reset(reset), .osc_clk(osc_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .time_now(time_now),
    .time_set_done(time_set_done), .sec_tick(sec_tick), .count_halt(count_halt),
    .ts_capture(ts_capture), .on_battery(on_battery), .tamper_input(tamper_input),
    .tamper_detect_out(tamper_detect_out), .tamper_detect_oe(tamper_detect_oe),
    .tamper_pullup_en(tamper_pullup_en), .cap_trim_code(cap_trim_code),
    .freq_trim_en(freq_trim_en), .freq_output_wave(freq_output_wave), .irq_freq_output_out(irq_freq_output_out),
    .irq_freq_output_oe(irq_freq_output_oe));
  rta_host_model host_u (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  always #50 clock = ~clock;
  initial begin
    #3.3;
    forever #7.5 osc_clk = ~osc_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts high samples of a stamp pulse (sel 0) or of the alarm pin (sel 1)
  task automatic count_hi(input int win, input bit sel, output int n);
    n = 0;
    repeat (win) begin
      step(1);
      if ((sel ? irq_freq_output_oe : ts_capture) === 1'b1) n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int a = 9; a < 18; a++) begin
      host_u.wr(5'(a), 8'h55 ^ 8'(a));
      host_u.rd(5'(a), d);
      check("register", (8'h55 ^ 8'(a)) & (a == 11 ? 8'h07 : 8'hFF), d);
    end
    host_u.rd(5'h12, d);
    check("no year alarm", 8'h00, d);
  endtask
  task automatic t_trim();
    for (int f = 0; f < 16; f++) begin
      host_u.wr(A_INTCTL, 8'(f));
      step(1);
      check("trim reach", 8'(f != 1), {7'h00, freq_trim_en});
    end
    for (int c = 0; c < 64; c += 21) begin
      host_u.wr(A_ATRIM, 8'(c));
      on_battery = c[0];
      step(4);
      check("cap code", 8'(c), {2'h0, cap_trim_code});
    end
    host_u.wr(A_ATRIM, 8'hC0);
    on_battery = 1'b1;
    step(4);
    check("battery cap", 8'h02, {2'h0, cap_trim_code});
    on_battery = 1'b0;
  endtask
  task automatic t_filter();
    int n;
    for (int f = 0; f < 4; f++) begin
      host_u.wr(A_STATUS, 8'h00);
      host_u.wr(A_TAMPER, 8'h80 | 8'(f));
      tamper_input = 1'b1;
      step(GLITCH[f]);
      tamper_input = 1'b0;
      count_hi(WIN[f], 1'b0, n);
      check("glitch stamps", 8'(f == 0), 8'(n));
      host_u.wr(A_STATUS, 8'h00);
      tamper_input = 1'b1;
      count_hi(WIN[f], 1'b0, n);
      check("held stamps", 8'h01, 8'(n));
      tamper_input = 1'b0;
      count_hi(WIN[f], 1'b0, n);
      tamper_input = 1'b1;
      count_hi(WIN[f], 1'b0, n);
      check("later stamps", 8'h00, 8'(n));
      tamper_input = 1'b0;
      count_hi(WIN[f], 1'b0, n);
    end
  endtask
  task automatic t_halt();
    int n;
    logic [7:0] d;
    host_u.wr(A_STATUS, 8'h00);
    host_u.wr(A_TAMPER, 8'hC1);
    tamper_input = 1'b1;
    count_hi(40, 1'b0, n);
    check("halted", 8'h01, {7'h00, count_halt});
    host_u.rd(A_STATUS, d);
    check("event flag", 8'h01, d);
    time_set_done = 1'b1;
    step(1);
    time_set_done = 1'b0;
    step(2);
    check("resumed", 8'h00, {7'h00, count_halt});
    host_u.rd(A_TAMPER, d);
    check("halt bit", 8'h81, d);
    on_battery = 1'b1;
    host_u.wr(A_TAMPER, 8'hA1);
    step(4);
    check("battery out", 8'h00, {7'h00, tamper_detect_oe});
    host_u.wr(A_TAMPER, 8'h81);
    step(4);
    check("battery out", 8'h01, {7'h00, tamper_detect_oe});
    on_battery = 1'b0;
    tamper_input = 1'b0;
    host_u.wr(A_TAMPER, 8'h41);
    host_u.wr(A_STATUS, 8'h00);
    tamper_input = 1'b1;
    count_hi(40, 1'b0, n);
    check("disabled", 8'h00, 8'(n) | {7'h00, count_halt});
    tamper_input = 1'b0;
  endtask
  task automatic alarm_at(input logic [7:0] s, input logic [7:0] m, output int n);
    time_now[0] = s;
    time_now[1] = m;
    count_hi(80, 1'b1, n);
  endtask
  task automatic t_alarm();
    int n;
    logic [7:0] d;
    for (int a = 12; a < 18; a++) begin
      host_u.wr(5'(a), a == 12 ? 8'hB0 : (a == 13 ? 8'h86 : 8'h00));
    end
    host_u.wr(A_INTCTL, 8'h40);
    alarm_at(8'h30, 8'h05, n);
    check("partial match", 8'h00, 8'(n));
    alarm_at(8'h30, 8'h06, n);
    check("single low", 8'h01, 8'(n > 77));
    alarm_at(8'h31, 8'h06, n);
    check("single held", 8'h50, 8'(n));
    host_u.wr(A_STATUS, 8'h00);
    step(2);
    check("cleared", 8'h00, {7'h00, irq_freq_output_oe});
    host_u.wr(A_INTCTL, 8'hC0);
    for (int i = 0; i < 2; i++) begin
      alarm_at(8'h31, 8'h06, n);
      alarm_at(8'h30, 8'h06, n);
      check("pulse width", 8'(PULSE), 8'(n));
    end
    host_u.rd(A_STATUS, d);
    check("repeat flag", 8'h02, d);
    host_u.wr(A_STATUS, 8'h83);
    host_u.rd(A_STATUS, d);
    check("auto clear", 8'h82, d);
    host_u.rd(A_STATUS, d);
    check("auto clear", 8'h80, d);
    host_u.wr(A_INTCTL, 8'h42);
    alarm_at(8'h31, 8'h06, n);
    alarm_at(8'h30, 8'h06, n);
    check("freq pin", 8'h50, 8'(n));
    freq_output_wave = 1'b1;
    step(2);
    check("freq pin", 8'h00, {7'h00, irq_freq_output_oe});
    host_u.rd(A_STATUS, d);
    check("no alarm", 8'h80, d);
  endtask
  // untrimmed second is 32768 osc periods of 15 ns, in 100 ns clocks
  task automatic t_tick();
    int n;
    n = 0;
    host_u.wr(A_DTRIM, 8'h00);
    while (sec_tick !== 1'b1) step(1);
    do begin
      step(1);
      n++;
    end while (sec_tick !== 1'b1);
    check("second length", 8'h01, 8'(n >= 4914 && n <= 4916));
  endtask

  initial begin
    {time_set_done, on_battery, tamper_input, freq_output_wave} = 4'h0;
    time_now = '0;
    repeat (16) @(posedge clock);
    #1 reset = 1'b0;
    t_regs();
    t_trim();
    t_filter();
    t_halt();
    t_alarm();
    t_tick();
    results();
  end
  initial begin
    #3_000_000;
    miscompares++;
    results();
  end
endmodule // rta_tamper_alarm_trim_tb_top
